//--- status_reporting.sv
/*
  status_reporting: test event, standard event and status byte logic of
  the remote-control interface, with service request line.
  Assumes the command parser delivers one decoded command per cycle with
  cmd_valid, and event inputs are one-cycle pulses (msg_waiting a level).
*/
// Notes on behaviour
// - jitter over threshold sets test bit 7
// - sequence finished sets test bit 6
// - out-of-mask generation request sets test bit 5
// - test enable bits align with test status
// - power-on sets standard event bit 7
// - standard bits 6, 3, 1 never set
// - bad command header sets standard bit 5
// - failed command or query sets bit 4
// - three query error cases set bit 2
// - operation complete command sets bit 0
// - standard enable bits align with status
// - summary bit 6 is enabled bits 5-3
// - summary bit follows changes of sources
// - bit 5 means enabled standard event set
// - bit 5 follows standard status and enable
// - bit 4 high while response waits
// - bit 3 means enabled test event set
// - bit 6 answers poll and status query
// - service enable holds bits 5-3 only
// - status bits stay set until cleared
// - all enables zero after power-up
// - clear status or query clears standard
// - service request line while summary set
`timescale 1ns/1ns
module status_reporting (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire status_report_pkg::cmd_code_t cmd_code,
  input wire logic [status_report_pkg::REG_W-1:0] cmd_data,
  input wire logic jitter_over,
  input wire logic seq_done,
  input wire logic gen_limit_hit,
  input wire logic cmd_header_err,
  input wire logic exec_err,
  input wire logic query_empty_err,
  input wire logic query_busy_err,
  input wire logic query_unterm_err,
  input wire logic op_done_cmd,
  input wire logic msg_waiting,
  output logic rsp_valid_q,
  output logic [status_report_pkg::REG_W-1:0] rsp_data_q,
  output logic [status_report_pkg::REG_W-1:0] status_byte_q,
  output logic srq_q
);
  import status_report_pkg::*;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_cmd(input cmd_code_t code);
    return cmd_valid && (cmd_code == code);
  endfunction

  logic wr_test_en;
  logic wr_std_en;
  logic wr_srq_en;
  logic clr_status;
  logic rd_std_status;

  always_comb begin
    wr_test_en = is_cmd(CMD_SET_TEST_ENABLE);
    wr_std_en = is_cmd(CMD_SET_STD_ENABLE);
    wr_srq_en = is_cmd(CMD_SET_SRQ_ENABLE);
    clr_status = is_cmd(CMD_CLEAR_STATUS);
    // reading the standard status empties it
    rd_std_status = is_cmd(CMD_READ_STD_STATUS);
  end

  // ----------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------
  logic [REG_W-1:0] test_set;
  logic [REG_W-1:0] std_set;

  always_comb begin
    test_set = '0;
    test_set[TE_JITTER_BIT] = jitter_over;
    test_set[TE_SEQ_DONE_BIT] = seq_done;
    test_set[TE_GEN_LIMIT_BIT] = gen_limit_hit;
    // bits 6, 3 and 1 have no source at all
    std_set = '0;
    std_set[SE_CMD_ERR_BIT] = cmd_header_err;
    std_set[SE_EXEC_ERR_BIT] = exec_err;
    std_set[SE_QUERY_ERR_BIT] = query_empty_err | query_busy_err | query_unterm_err;
    std_set[SE_OP_DONE_BIT] = op_done_cmd;
  end

  // ----------------------------------------------------------------
  // event registers
  // ----------------------------------------------------------------
  logic [REG_W-1:0] test_status;
  logic [REG_W-1:0] test_enable;
  logic test_summary_next;
  logic [REG_W-1:0] std_status;
  logic [REG_W-1:0] std_enable;
  logic std_summary_next;

  event_latch #(
    .WIDTH(REG_W),
    .DEFINED(TE_DEFINED),
    .RESET_VALUE(TE_RESET),
    .ENABLE_RESET(ENABLE_RESET)
  ) u_test_events (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_pulse(test_set),
    .clear(clr_status),
    .enable_wr(wr_test_en),
    .enable_data(cmd_data),
    .status_q(test_status),
    .enable_q(test_enable),
    .summary_next(test_summary_next)
  );

  // power-on bit is the reset value of the standard register
  event_latch #(
    .WIDTH(REG_W),
    .DEFINED(SE_DEFINED),
    .RESET_VALUE(SE_RESET),
    .ENABLE_RESET(ENABLE_RESET)
  ) u_std_events (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .set_pulse(std_set),
    .clear(clr_status | rd_std_status),
    .enable_wr(wr_std_en),
    .enable_data(cmd_data),
    .status_q(std_status),
    .enable_q(std_enable),
    .summary_next(std_summary_next)
  );

  // ----------------------------------------------------------------
  // status byte and service request
  // ----------------------------------------------------------------
  logic [REG_W-1:0] srq_enable_q;
  logic [REG_W-1:0] srq_enable_d;
  logic [REG_W-1:0] status_byte_d;
  logic srq_d;

  always_comb begin
    // only bits 5..3 have enables; bit 6 of the enable is always held at 0
    srq_enable_d = wr_srq_en ? (cmd_data & SR_DEFINED) : srq_enable_q;
    status_byte_d = '0;
    status_byte_d[SB_EVENT_BIT] = std_summary_next;
    status_byte_d[SB_MSG_BIT] = msg_waiting;
    status_byte_d[SB_TEST_BIT] = test_summary_next;
    // recomputed every cycle from next values of sources and enables
    status_byte_d[SB_SUMMARY_BIT] = |(status_byte_d & srq_enable_d);
    srq_d = status_byte_d[SB_SUMMARY_BIT];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      srq_enable_q <= ENABLE_RESET;
      status_byte_q <= STATUS_BYTE_RESET;
      srq_q <= 1'b0;
    end else begin
      srq_enable_q <= srq_enable_d;
      status_byte_q <= status_byte_d;
      srq_q <= srq_d;
    end
  end

  // ----------------------------------------------------------------
  // query responses
  // ----------------------------------------------------------------
  logic rsp_valid_d;
  logic [REG_W-1:0] rsp_data_d;

  always_comb begin
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    if (cmd_valid) begin
      case (cmd_code)
        CMD_READ_TEST_STATUS: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = test_status;
        end
        CMD_READ_TEST_ENABLE: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = test_enable;
        end
        CMD_READ_STD_STATUS: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = std_status;
        end
        CMD_READ_STD_ENABLE: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = std_enable;
        end
        CMD_READ_SRQ_ENABLE: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = srq_enable_q;
        end
        // bit 6 stands as the master summary here
        CMD_READ_STATUS_BYTE: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = status_byte_q;
        end
        // bit 6 stands as the request bit, same value as the line
        CMD_SERIAL_POLL: begin
          rsp_valid_d = 1'b1;
          rsp_data_d = status_byte_q;
          rsp_data_d[SB_SUMMARY_BIT] = srq_q;
        end
        default: begin
          rsp_valid_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_jitter_sets;
    jitter_over |=> test_status[TE_JITTER_BIT];
  endproperty
  a_jitter_sets: assert property (p_jitter_sets) else $error("jitter flag not set");

  property p_seq_sets;
    seq_done |=> test_status[TE_SEQ_DONE_BIT];
  endproperty
  a_seq_sets: assert property (p_seq_sets) else $error("sequence flag not set");

  property p_limit_sets;
    gen_limit_hit |=> test_status[TE_GEN_LIMIT_BIT] ##1
      (test_status[TE_GEN_LIMIT_BIT] || $past(clr_status));
  endproperty
  a_limit_sets: assert property (p_limit_sets) else $error("limit flag not held");

  property p_unused_zero;
    (std_status & ~SE_DEFINED) == '0 && (test_status & ~TE_DEFINED) == '0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("undefined bit set");

  property p_query_err;
    (query_empty_err || query_busy_err || query_unterm_err) |=> std_status[SE_QUERY_ERR_BIT];
  endproperty
  a_query_err: assert property (p_query_err) else $error("query error lost");

  property p_read_clears;
    (rd_std_status && std_set == '0) |=> std_status == '0 && rsp_valid_q &&
      rsp_data_q == $past(std_status);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("standard read not cleared");

  property p_summary;
    status_byte_q[SB_SUMMARY_BIT] ==
      |(status_byte_q & srq_enable_q & SR_DEFINED);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_event_bit;
    status_byte_q[SB_EVENT_BIT] == |(std_status & std_enable);
  endproperty
  a_event_bit: assert property (p_event_bit) else $error("event summary wrong");

  property p_test_bit;
    status_byte_q[SB_TEST_BIT] == |(test_status & test_enable);
  endproperty
  a_test_bit: assert property (p_test_bit) else $error("test summary wrong");

  property p_msg_bit;
    msg_waiting |=> status_byte_q[SB_MSG_BIT];
  endproperty
  a_msg_bit: assert property (p_msg_bit) else $error("message bit missing");

  property p_srq_line;
    srq_q == status_byte_q[SB_SUMMARY_BIT] && (status_byte_q & 8'h87) == '0;
  endproperty
  a_srq_line: assert property (p_srq_line) else $error("request line mismatch");

  property p_poll_rqs;
    is_cmd(CMD_SERIAL_POLL) |=> rsp_valid_q && rsp_data_q[SB_SUMMARY_BIT] == $past(srq_q);
  endproperty
  a_poll_rqs: assert property (p_poll_rqs) else $error("poll bit wrong");

  c_srq_rise: cover property ($rose(srq_q));
  c_read_std: cover property (rd_std_status && std_status != '0);
  c_poll_req: cover property (is_cmd(CMD_SERIAL_POLL) && srq_q);
  c_set_clear_same: cover property (clr_status && test_set != '0);

endmodule

//--- status_report_pkg.sv
/*
  status_report_pkg: constants and command codes shared by the status
  reporting logic. Assumes one 8-bit register width throughout.
*/
package status_report_pkg;

  localparam int REG_W = 8;

  // ----------------------------------------------------------------
  // test event status bit positions
  // ----------------------------------------------------------------
  localparam int TE_JITTER_BIT = 7;
  localparam int TE_SEQ_DONE_BIT = 6;
  localparam int TE_GEN_LIMIT_BIT = 5;
  localparam logic [7:0] TE_DEFINED = 8'he0;
  localparam logic [7:0] TE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // standard event status bit positions
  // ----------------------------------------------------------------
  localparam int SE_POWER_ON_BIT = 7;
  localparam int SE_CMD_ERR_BIT = 5;
  localparam int SE_EXEC_ERR_BIT = 4;
  localparam int SE_QUERY_ERR_BIT = 2;
  localparam int SE_OP_DONE_BIT = 0;
  localparam logic [7:0] SE_DEFINED = 8'hb5;
  localparam logic [7:0] SE_RESET = 8'h80;

  // ----------------------------------------------------------------
  // status byte bit positions
  // ----------------------------------------------------------------
  localparam int SB_SUMMARY_BIT = 6;
  localparam int SB_EVENT_BIT = 5;
  localparam int SB_MSG_BIT = 4;
  localparam int SB_TEST_BIT = 3;
  localparam logic [7:0] SR_DEFINED = 8'h38;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] STATUS_BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // commands from the remote controller
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_READ_TEST_STATUS = 4'h0,
    CMD_SET_TEST_ENABLE = 4'h1,
    CMD_READ_TEST_ENABLE = 4'h2,
    CMD_READ_STD_STATUS = 4'h3,
    CMD_SET_STD_ENABLE = 4'h4,
    CMD_READ_STD_ENABLE = 4'h5,
    CMD_READ_STATUS_BYTE = 4'h6,
    CMD_SET_SRQ_ENABLE = 4'h7,
    CMD_READ_SRQ_ENABLE = 4'h8,
    CMD_CLEAR_STATUS = 4'h9,
    CMD_SERIAL_POLL = 4'ha
  } cmd_code_t;

endpackage

//--- event_latch.sv
/*
  event_latch: one sticky status register with its enable register and
  enabled-summary output. Assumes set pulses and clear are synchronous
  one-cycle strobes from the owning block.
*/
`timescale 1ns/1ns
module event_latch #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] DEFINED = '1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] ENABLE_RESET = '0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic clear,
  input wire logic enable_wr,
  input wire logic [WIDTH-1:0] enable_data,
  output logic [WIDTH-1:0] status_q,
  output logic [WIDTH-1:0] enable_q,
  output logic summary_next
);

  logic [WIDTH-1:0] status_d;
  logic [WIDTH-1:0] enable_d;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    // set wins over clear; undefined bits never set
    status_d = ((clear ? '0 : status_q) | set_pulse) & DEFINED;
    enable_d = enable_wr ? (enable_data & DEFINED) : enable_q;
    summary_next = |(status_d & enable_d);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= RESET_VALUE;
      enable_q <= ENABLE_RESET;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
    end
  end

  property p_sticky;
    @(posedge sys_clk) disable iff (!reset_n)
    !clear |=> ((status_q & $past(status_q)) == $past(status_q));
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

endmodule

//--- remote_ctrl_model.sv
/*
  remote_ctrl_model: remote controller that issues set commands, queries
  and serial polls on the command port. It assumes that the answer to a
  read arrives on the same edge that takes the command.
*/
`timescale 1ns/1ns
module remote_ctrl_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output status_report_pkg::cmd_code_t cmd_code,
  output logic [status_report_pkg::REG_W-1:0] cmd_data,
  input wire logic rsp_valid_q,
  input wire logic [status_report_pkg::REG_W-1:0] rsp_data_q
);
  import status_report_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_READ_TEST_STATUS;
    cmd_data = 8'h00;
  end

  // ----------------------------------------------------------------
  // one command, driven on a falling edge, held over one rising edge
  // ----------------------------------------------------------------
  task automatic issue(input cmd_code_t code, input logic [REG_W-1:0] data);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_data = data;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // released lines change, so a stale value cannot pass as held
    cmd_code = cmd_code_t'(~code);
    cmd_data = ~data;
  endtask

  // ----------------------------------------------------------------
  // status byte query or serial poll picks bit 6 meaning by code
  // ----------------------------------------------------------------
  task automatic query(input cmd_code_t code, output logic [REG_W-1:0] data,
                       output logic ok);
    // answer strobe stands only in the cycle after the taking edge
    issue(code, 8'h00);
    ok = rsp_valid_q;
    data = rsp_data_q;
  endtask
endmodule

//--- instrument_status_reporting_tb.sv
/*
  instrument_status_reporting_tb: self-checking bench for the status and
  event reporting logic. It assumes the remote controller model drives
  the command port and the bench drives event pulses on falling edges.
*/
`timescale 1ns/1ns
module instrument_status_reporting_tb;
  import status_report_pkg::*;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid;
  cmd_code_t cmd_code;
  logic [7:0] cmd_data;
  logic [8:0] ev = 9'h000;
  logic msg_waiting = 1'b0;
  logic rsp_valid_q;
  logic srq_q;
  logic [7:0] rsp_data_q;
  logic [7:0] status_byte_q;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] std_bit [3:8] = '{8'h20, 8'h10, 8'h04, 8'h04, 8'h04, 8'h01};

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  status_reporting u_status_reporting (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .jitter_over(ev[0]),
    .seq_done(ev[1]), .gen_limit_hit(ev[2]), .cmd_header_err(ev[3]),
    .exec_err(ev[4]), .query_empty_err(ev[5]), .query_busy_err(ev[6]),
    .query_unterm_err(ev[7]), .op_done_cmd(ev[8]), .msg_waiting(msg_waiting),
    .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .status_byte_q(status_byte_q), .srq_q(srq_q)
  );

  remote_ctrl_model u_remote_ctrl_model (
    .sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input cmd_code_t code, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_remote_ctrl_model.query(code, d, ok);
    chk8({7'h00, ok}, 8'h01, "answer strobe");
    chk8(d, exp, code.name());
  endtask

  task automatic wr(input cmd_code_t code, input logic [7:0] data);
    u_remote_ctrl_model.issue(code, data);
  endtask

  // settle two edges, then status byte and request line together
  task automatic chk_sb(input logic [7:0] exp);
    repeat (2) @(negedge sys_clk);
    chk8(status_byte_q, exp, "status byte");
    chk8({7'h00, srq_q}, {7'h00, exp[6]}, "service request");
  endtask

  task automatic pulse(input int idx);
    @(negedge sys_clk);
    ev[idx] = 1'b1;
    @(negedge sys_clk);
    ev[idx] = 1'b0;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    rd(CMD_READ_TEST_STATUS, 8'h00);
    rd(CMD_READ_STD_STATUS, 8'h80);
    rd(CMD_READ_STD_STATUS, 8'h00);
    rd(CMD_READ_TEST_ENABLE, 8'h00);
    rd(CMD_READ_STD_ENABLE, 8'h00);
    rd(CMD_READ_SRQ_ENABLE, 8'h00);
    chk_sb(8'h00);
    wr(CMD_SET_TEST_ENABLE, 8'hff);
    wr(CMD_SET_STD_ENABLE, 8'hff);
    wr(CMD_SET_SRQ_ENABLE, 8'hff);
    rd(CMD_READ_TEST_ENABLE, 8'he0);
    rd(CMD_READ_STD_ENABLE, 8'hb5);
    rd(CMD_READ_SRQ_ENABLE, 8'h38);
    // codes past the table are dropped
    wr(cmd_code_t'(4'hc), 8'h00);
    rd(CMD_READ_SRQ_ENABLE, 8'h38);
    // test events, gated by position
    wr(CMD_SET_TEST_ENABLE, 8'h80);
    wr(CMD_SET_SRQ_ENABLE, 8'h08);
    pulse(1);
    chk_sb(8'h00);
    pulse(0);
    chk_sb(8'h48);
    wr(CMD_SET_SRQ_ENABLE, 8'h00);
    chk_sb(8'h08);
    pulse(2);
    rd(CMD_READ_TEST_STATUS, 8'he0);
    rd(CMD_READ_TEST_STATUS, 8'he0);
    wr(CMD_CLEAR_STATUS, 8'h00);
    rd(CMD_READ_TEST_STATUS, 8'h00);
    chk_sb(8'h00);
    // standard events, one source at a time, cleared by the read
    wr(CMD_SET_SRQ_ENABLE, 8'h20);
    for (int i = 3; i <= 8; i++) begin
      pulse(i);
      chk_sb(8'h60);
      rd(CMD_READ_STD_STATUS, std_bit[i]);
      chk_sb(8'h00);
    end
    wr(CMD_SET_STD_ENABLE, 8'h00);
    pulse(3);
    chk_sb(8'h00);
    wr(CMD_SET_STD_ENABLE, 8'h20);
    chk_sb(8'h60);
    rd(CMD_READ_STD_STATUS, 8'h20);
    // queued output and both ways of reading the status byte
    @(negedge sys_clk);
    msg_waiting = 1'b1;
    wr(CMD_SET_SRQ_ENABLE, 8'h10);
    chk_sb(8'h50);
    rd(CMD_READ_STATUS_BYTE, 8'h50);
    rd(CMD_SERIAL_POLL, 8'h50);
    @(negedge sys_clk);
    msg_waiting = 1'b0;
    chk_sb(8'h00);
    wrap_up();
  end
endmodule
